// ===== rtl/hsdc_pkg.sv
// package of constants and types for the speed and direction core
package hsdc_pkg;
    // ****************************************
    // widths and thresholds
    // ****************************************
    localparam int HSDC_SW = 12;
    localparam logic [HSDC_SW-1:0] HSDC_LIMIT_DEF = 12'h010;
    localparam int HSDC_NOISE_MULT = 2;
    localparam int HSDC_HYST_SHIFT = 3;
    localparam int HSDC_CAL_PULSES = 3;
    // ****************************************
    // timing
    // ****************************************
    localparam int HSDC_CLK_MHZ = 125;
    localparam int HSDC_LOW_NS = 1000;
    localparam int HSDC_SPEED_NS = 4000;
    localparam int HSDC_DIR_A_NS = 8000;
    localparam int HSDC_DIR_B_NS = 16000;
    localparam int HSDC_LOW_CYC = HSDC_LOW_NS * HSDC_CLK_MHZ / 1000;
    localparam int HSDC_SPEED_CYC = HSDC_SPEED_NS * HSDC_CLK_MHZ / 1000;
    localparam int HSDC_DIR_A_CYC = HSDC_DIR_A_NS * HSDC_CLK_MHZ / 1000;
    localparam int HSDC_DIR_B_CYC = HSDC_DIR_B_NS * HSDC_CLK_MHZ / 1000;
    localparam int HSDC_CW = 12;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {HSDC_P_SPEED, HSDC_P_DIR_A, HSDC_P_DIR_B} hsdc_kind_type;
    typedef struct packed {
        logic active;
        logic high;
        hsdc_kind_type kind;
    } hsdc_out_type;
    typedef enum logic [1:0] {HSDC_IDLE, HSDC_PRELOW, HSDC_PULSE} hsdc_ostate_type;
endpackage : hsdc_pkg

// ===== rtl/hsdc_core.sv
// speed and direction core with start-up calibration and pulse output
// Functional notes
// - first rising edge triggers first pulse
// - next rising edge triggers second pulse
// - uncalibrated: noise threshold, at least twice limit
// - offset update after two extrema, slope-matched
// - offset updates independent of output switching
// - successful correction enters calibrated hysteresis mode
// - small signals: pulses one, two always
// - hysteresis one eighth amplitude, floor limit
// - excursions below hysteresis cause no switching
// - direction sampled at rising speed zero crossings
// - first pulse carries speed only
// - vibration-classified excursions withhold pulses
// - direction suppression only once calibrated
// - undervoltage monitor armed at first switching
// - armed undervoltage forces high current output
// - reset-level supply restarts uncalibrated calibration
// - pulse follows elapsed pre-low period
// - direction carried in output pulses
`timescale 1ns/1ps
module hsdc_core
    import hsdc_pkg::*;
#(
    parameter logic [HSDC_SW-1:0] SPEED_LIMIT = HSDC_LIMIT_DEF,
    parameter int LOW_CYC = HSDC_LOW_CYC,
    parameter int SPEED_CYC = HSDC_SPEED_CYC,
    parameter int DIR_A_CYC = HSDC_DIR_A_CYC,
    parameter int DIR_B_CYC = HSDC_DIR_B_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // digitized converter samples, same clock
    input wire logic signed [hsdc_pkg::HSDC_SW-1:0] speed_in,
    input wire logic signed [hsdc_pkg::HSDC_SW-1:0] dir_in,
    // supply monitor comparators, asynchronous
    input wire logic uv_in,
    input wire logic por_in,
    // output
    output hsdc_pkg::hsdc_out_type out_out,
    output logic calibrated_out,
    output logic signed [hsdc_pkg::HSDC_SW-1:0] offset_out
);
    import hsdc_pkg::*;

    initial begin
        if (LOW_CYC < 1 || SPEED_CYC < 1 || SPEED_CYC >= DIR_A_CYC || DIR_A_CYC >= DIR_B_CYC
            || DIR_B_CYC >= (1 << HSDC_CW)) begin
            $error("hsdc_core: bad pulse timing parameters");
        end
    end

    function automatic logic [HSDC_SW-1:0] hsdc_max(input logic [HSDC_SW-1:0] a,
                                                    input logic [HSDC_SW-1:0] b);
        hsdc_max = (a > b) ? a : b;
    endfunction : hsdc_max

    // ****************************************
    // supply synchronisers
    // ****************************************
    logic [1:0] uv_sync_r, por_sync_r;
    always_ff @(posedge sys_clk_in) begin
        uv_sync_r <= {uv_sync_r[0], uv_in};
        por_sync_r <= {por_sync_r[0], por_in};
    end
    logic uv_s, rst_n;
    assign uv_s = uv_sync_r[1];
    // supply under reset level restarts everything except the two supply synchronisers
    assign rst_n = resetn_in && !por_sync_r[1];

    // ****************************************
    // signal tracking
    // ****************************************
    logic signed [HSDC_SW-1:0] sig_c;
    logic signed [HSDC_SW-1:0] offset_r, offset_nxt, ref_r, ref_nxt;
    logic signed [HSDC_SW-1:0] max_r, max_nxt, min_r, min_nxt;
    logic [HSDC_SW-1:0] amp_r, amp_nxt, thr_c, noise_c, hyst_c;
    logic level_r, level_nxt, cal_r, cal_nxt, dirv_r, dirv_nxt, dir_r, dir_nxt;
    logic [1:0] ext_r, ext_nxt;
    logic [1:0] npulse_r, npulse_nxt;
    logic rise_c, fall_c, vib_c, fire_c, dir_now_c;
    logic signed [HSDC_SW-1:0] mid_c;

    assign sig_c = HSDC_SW'(speed_in - offset_r);
    // noise threshold never below twice the limit
    assign noise_c = hsdc_max(HSDC_SW'(HSDC_NOISE_MULT * SPEED_LIMIT), amp_r);
    // hysteresis one eighth of amplitude, floored
    assign hyst_c = hsdc_max(HSDC_SW'(amp_r >> HSDC_HYST_SHIFT), SPEED_LIMIT);
    // calibrated switches at hysteresis, else noise threshold
    assign thr_c = cal_r ? hyst_c : noise_c;
    // excursions smaller than threshold never switch
    assign rise_c = !level_r && (sig_c - ref_r > $signed({1'b0, thr_c}));
    assign fall_c = level_r && (ref_r - sig_c > $signed({1'b0, thr_c}));
    // center probe sampled at zero crossing, 90 degree lead or lag
    assign dir_now_c = !dir_in[HSDC_SW-1];
    // reversal seen only once calibrated and direction valid
    assign vib_c = cal_r && dirv_r && (dir_now_c != dir_r);
    // first two pulses unconditional
    assign fire_c = rise_c && ((npulse_r < 2'h2) || !vib_c);
    assign mid_c = HSDC_SW'((max_r + min_r) >>> 1);

    always_comb begin
        offset_nxt = offset_r;
        ref_nxt = ref_r;
        max_nxt = max_r;
        min_nxt = min_r;
        amp_nxt = amp_r;
        level_nxt = level_r;
        cal_nxt = cal_r;
        ext_nxt = ext_r;
        dirv_nxt = dirv_r;
        dir_nxt = dir_r;
        npulse_nxt = npulse_r;
        if (level_r) begin
            if (sig_c > ref_r) ref_nxt = sig_c;
            if (sig_c > max_r) max_nxt = sig_c;
        end else begin
            if (sig_c < ref_r) ref_nxt = sig_c;
            if (sig_c < min_r) min_nxt = sig_c;
        end
        if (rise_c || fall_c) begin
            level_nxt = rise_c;
            ref_nxt = sig_c;
            if (ext_r != 2'h2) ext_nxt = ext_r + 2'h1;
            // amplitude is half the swing, so the noise threshold sits near mid-swing
            amp_nxt = HSDC_SW'((max_r - min_r) >>> 1);
            // offset follows slope: positive only on rising edge
            if (ext_r == 2'h2 && ((rise_c && mid_c > 0) || (fall_c && mid_c < 0))) begin
                offset_nxt = HSDC_SW'(offset_r + mid_c);
                cal_nxt = 1'b1;
            end
            if (rise_c) begin
                dir_nxt = dir_now_c;
                if (npulse_r != 2'h3) npulse_nxt = npulse_r + 2'h1;
                // first pulse leaves direction invalid
                dirv_nxt = (npulse_r != 2'h0);
            end
            // restart only the coming half wave's extreme; the other feeds the midpoint
            if (rise_c) max_nxt = sig_c;
            else min_nxt = sig_c;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n) begin
            offset_r <= '0;
            ref_r <= '0;
            max_r <= '0;
            min_r <= '0;
            amp_r <= '0;
            level_r <= 1'b0;
            cal_r <= 1'b0;
            ext_r <= 2'h0;
            dirv_r <= 1'b0;
            dir_r <= 1'b0;
            npulse_r <= 2'h0;
        end else begin
            offset_r <= offset_nxt;
            ref_r <= ref_nxt;
            max_r <= max_nxt;
            min_r <= min_nxt;
            amp_r <= amp_nxt;
            level_r <= level_nxt;
            cal_r <= cal_nxt;
            ext_r <= ext_nxt;
            dirv_r <= dirv_nxt;
            dir_r <= dir_nxt;
            npulse_r <= npulse_nxt;
        end
    end

    // ****************************************
    // output protocol
    // ****************************************
    hsdc_ostate_type ost_r, ost_nxt;
    logic [HSDC_CW-1:0] cnt_r, cnt_nxt;
    hsdc_kind_type kind_r, kind_nxt;
    logic armed_r, armed_nxt;
    hsdc_out_type out_r, out_nxt;

    function automatic logic [HSDC_CW-1:0] hsdc_len(input hsdc_kind_type k);
        case (k)
            HSDC_P_DIR_A: hsdc_len = HSDC_CW'(DIR_A_CYC);
            HSDC_P_DIR_B: hsdc_len = HSDC_CW'(DIR_B_CYC);
            default: hsdc_len = HSDC_CW'(SPEED_CYC);
        endcase
    endfunction : hsdc_len

    always_comb begin
        ost_nxt = ost_r;
        cnt_nxt = cnt_r;
        kind_nxt = kind_r;
        armed_nxt = armed_r;
        case (ost_r)
            HSDC_IDLE: begin
                if (fire_c) begin
                    ost_nxt = HSDC_PRELOW;
                    cnt_nxt = HSDC_CW'(LOW_CYC);
                    // direction into the pulse kind
                    kind_nxt = !dirv_nxt ? HSDC_P_SPEED : (dir_now_c ? HSDC_P_DIR_A : HSDC_P_DIR_B);
                    armed_nxt = 1'b1;
                end
            end
            HSDC_PRELOW: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == HSDC_CW'(1)) begin
                    ost_nxt = HSDC_PULSE;
                    cnt_nxt = hsdc_len(kind_r);
                end
            end
            HSDC_PULSE: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_r == HSDC_CW'(1)) ost_nxt = HSDC_IDLE;
            end
            default: ost_nxt = HSDC_IDLE;
        endcase
        out_nxt.kind = kind_nxt;
        out_nxt.active = (ost_nxt == HSDC_PULSE);
        // armed undervoltage holds high current
        out_nxt.high = (ost_nxt == HSDC_PULSE) || (armed_r && uv_s);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n) begin
            ost_r <= HSDC_IDLE;
            cnt_r <= '0;
            kind_r <= HSDC_P_SPEED;
            armed_r <= 1'b0;
            out_r <= '0;
        end else begin
            ost_r <= ost_nxt;
            cnt_r <= cnt_nxt;
            kind_r <= kind_nxt;
            armed_r <= armed_nxt;
            out_r <= out_nxt;
        end
    end

    assign out_out = out_r;
    assign calibrated_out = cal_r;
    assign offset_out = offset_r;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_prelow;
        ost_r == HSDC_PRELOW && cnt_r == HSDC_CW'(1);
    endsequence
    a_pulse_after_low: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        s_prelow |=> out_r.active) else $error("pulse missing after pre-low");
    a_uv_forces_high: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        armed_r && uv_s |=> out_r.high) else $error("undervoltage not high");
    a_uv_unarmed: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !armed_r && ost_r == HSDC_IDLE |-> !out_r.high) else $error("early high");
    a_first_speed: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        npulse_r == 2'h0 && fire_c |=> kind_r == HSDC_P_SPEED) else $error("first kind");
    a_first_two: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        rise_c && npulse_r < 2'h2 && ost_r == HSDC_IDLE |=> ost_r == HSDC_PRELOW)
        else $error("early pulse lost");
    a_hyst_floor: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        hyst_c >= SPEED_LIMIT) else $error("hysteresis below floor");
    a_noise_floor: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !cal_r |-> thr_c >= HSDC_SW'(2 * SPEED_LIMIT)) else $error("noise floor");
    a_dir_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !cal_r |-> !vib_c) else $error("direction suppression early");
    a_cal_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        cal_r |=> cal_r) else $error("calibration lost");
    a_pulse_len: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        s_prelow |=> cnt_r == hsdc_len(kind_r)) else $error("pulse length");
    // a rise seen while the output is free to start a new frame
    sequence s_idle_rise;
        ost_r == HSDC_IDLE && rise_c;
    endsequence
    a_second_pulse: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        s_idle_rise ##0 npulse_r == 2'h1 |=> ost_r == HSDC_PRELOW)
        else $error("second pulse lost");
    a_vib_withhold: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        s_idle_rise ##0 (vib_c && npulse_r >= 2'h2) |=> ost_r == HSDC_IDLE)
        else $error("vibration pulse sent");
    a_dir_kind: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        s_idle_rise ##0 (fire_c && npulse_r != 2'h0)
        |=> kind_r == (dir_r ? HSDC_P_DIR_A : HSDC_P_DIR_B))
        else $error("direction not carried");
    // offset may move only on a slope-matched crossing, never on its own
    a_offset_slope: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $changed(offset_r) |-> ($past(rise_c) && $past(mid_c) > 0)
        || ($past(fall_c) && $past(mid_c) < 0)) else $error("offset against slope");
    a_cal_on_offset: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $rose(cal_r) |-> $changed(offset_r)) else $error("calibrated without offset");
    a_prelow_quiet: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        ost_r == HSDC_PRELOW |-> !out_r.active) else $error("pulse during pre-low");
    a_active_high: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        out_r.active |-> out_r.high) else $error("pulse without high current");
endmodule : hsdc_core

// ===== verification/hsdc_tcu_model.sv
// controller model that counts current pulses and sorts them by width
`timescale 1ns/1ps
module hsdc_tcu_model
    import hsdc_pkg::*;
#(
    // defaults follow the bench's shortened pulse lengths
    parameter int SPEED_CYC = 8,
    parameter int DIR_A_CYC = 12,
    parameter int DIR_B_CYC = 16
) (
    // clock
    input wire logic sys_clk_in,
    // current line as seen at the controller
    input wire hsdc_pkg::hsdc_out_type line_in,
    // decoded pulses
    output int pulse_cnt_out,
    output hsdc_pkg::hsdc_kind_type kind_out
);
    int width_r = 0;
    initial pulse_cnt_out = 0;
    initial kind_out = HSDC_P_DIR_B;
    // ****************************************
    // width classification
    // ****************************************
    // split halfway between nominal lengths, so one cycle of jitter is tolerated
    always @(posedge sys_clk_in) begin
        if (line_in.high === 1'b1) begin
            width_r <= width_r + 1;
        end else if (width_r > 0) begin
            pulse_cnt_out <= pulse_cnt_out + 1;
            if (width_r < (SPEED_CYC + DIR_A_CYC) / 2) begin
                kind_out <= HSDC_P_SPEED;
            end else if (width_r < (DIR_A_CYC + DIR_B_CYC) / 2) begin
                kind_out <= HSDC_P_DIR_A;
            end else begin
                kind_out <= HSDC_P_DIR_B;
            end
            width_r <= 0;
        end
    end
endmodule : hsdc_tcu_model

// ===== verification/testbench.sv
// self-checking testbench for the speed and direction core
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    import hsdc_pkg::*;
    localparam int P = 64;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic signed [HSDC_SW-1:0] speed_in = '0;
    logic signed [HSDC_SW-1:0] dir_in = '0;
    logic uv_in = 1'b0;
    logic por_in = 1'b0;
    hsdc_out_type out_out;
    logic calibrated_out;
    logic signed [HSDC_SW-1:0] offset_out;
    int pulse_cnt;
    hsdc_kind_type last_kind;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'h5424;
    int big;
    int c0;
    // ****************************************
    // design and controller
    // ****************************************
    hsdc_core #(.LOW_CYC(4), .SPEED_CYC(8), .DIR_A_CYC(12), .DIR_B_CYC(16)) dut (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .speed_in(speed_in),
        .dir_in(dir_in),
        .uv_in(uv_in),
        .por_in(por_in),
        .out_out(out_out),
        .calibrated_out(calibrated_out),
        .offset_out(offset_out)
    );
    hsdc_tcu_model tcu (
        .sys_clk_in(sys_clk_in),
        .line_in(out_out),
        .pulse_cnt_out(pulse_cnt),
        .kind_out(last_kind)
    );
    initial begin
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    // triangle starting at its trough, so each period opens with a rise
    function automatic logic signed [HSDC_SW-1:0] tri_wave(int ph, int amp);
        int p;
        p = ph % P;
        return HSDC_SW'((p < P / 2) ? -amp + 4 * amp * p / P : 3 * amp - 4 * amp * p / P);
    endfunction : tri_wave
    // leading center probe is positive at the rising zero crossing
    function automatic hsdc_kind_type exp_kind(bit lead);
        return lead ? HSDC_P_DIR_A : HSDC_P_DIR_B;
    endfunction : exp_kind
    task automatic run(int n, int amp, bit lead);
        for (int i = 0; i < n * P; i++) begin
            @(negedge sys_clk_in);
            // constant bias so the first offset update is positive on a rise
            speed_in <= tri_wave(i, amp) + HSDC_SW'($random(seed) % 3) + HSDC_SW'(16);
            dir_in <= tri_wave(lead ? i + P / 4 : i + 3 * P / 4, amp);
        end
    endtask : run
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        big = 400 + ($random(seed) & 255);
        repeat (20) @(negedge sys_clk_in);
        `CHK(out_out, 4'h0)
        resetn_in <= 1'b1;
        run(2, 12, 1'b1);
        `CHK(pulse_cnt, 0)
        uv_in <= 1'b1;
        repeat (10) @(negedge sys_clk_in);
        `CHK(out_out.high, 1'b0)
        uv_in <= 1'b0;
        run(1, big, 1'b1);
        `CHK(pulse_cnt, 1)
        `CHK(last_kind, HSDC_P_SPEED)
        run(1, big, 1'b1);
        `CHK(pulse_cnt, 2)
        run(4, big, 1'b1);
        `CHK(calibrated_out, 1'b1)
        `CHK(pulse_cnt >= 5, 1'b1)
        `CHK(last_kind, exp_kind(1'b1))
        `CHK(offset_out != 0, 1'b1)
        run(1, 4, 1'b1);
        c0 = pulse_cnt;
        run(3, 4, 1'b1);
        `CHK(pulse_cnt, c0)
        run(4, big, 1'b0);
        `CHK(last_kind, exp_kind(1'b0))
        uv_in <= 1'b1;
        repeat (6) @(negedge sys_clk_in);
        for (int k = 0; k < 8; k++) begin
            `CHK(out_out.high, 1'b1)
            repeat (3) @(negedge sys_clk_in);
        end
        uv_in <= 1'b0;
        repeat (30) @(negedge sys_clk_in);
        `CHK(out_out.high, 1'b0)
        por_in <= 1'b1;
        repeat (4) @(negedge sys_clk_in);
        por_in <= 1'b0;
        repeat (2) @(negedge sys_clk_in);
        `CHK(calibrated_out, 1'b0)
        run(1, big, 1'b1);
        `CHK(last_kind, HSDC_P_SPEED)
        `CHK(calibrated_out, 1'b0)
        conclude();
    end
endmodule : testbench
